// file: sbd_regs.svh
// Contract
// R1 - 0x33+4sz: dump read, delay, status, data
// R2 - 0x12+4sz: fill write next address, dack
// R3 - 0x13+4sz: fill write, delay, status
// R4 - 0x08 resume in background mode, dack
// R5 - 0x0C resume, ack on background reentry
// R6 - handshake off: resume-until equals resume
// R7 - 0x60+crn register read, dack, 32 bits
// R8 - 0x30/0x31+4sz: addressed read, ack or status
// R9 - 0x10/0x11+4sz: addressed write, ack or status
// R10 - 0x07 trace read: two dack plus 32
// R11 - 0x50/0x51+4sz: reread same address
// R12 - 0x2D: control status read, 16 bits
// R13 - 0x0D: control status write, 16 bits
// R14 - 0x40+crn register write, then dack
// R15 - 0x95: mass erase, plain delay
// R16 - 0x09 single step in background mode
// R17 - host: high 4, low 128 slow cycles
// R18 - host: speed-up pulse, then release pin
// R19 - sync: discard, wait high, 16, 128, pulse
// R20 - sync response ends clearing overrun flag
// R21 - host times response low phase
// R22 - next falling edge starts command or sync
// R23 - sync request cancels a pending ack
// R24 - size: 00 byte, 01 word, else long
// R25 - host waits 16 cycles at delays
// R26 - dack: 16 no ack, or ack after 32
// R27 - status byte is control status low byte
`ifndef SBD_REGS_SVH
`define SBD_REGS_SVH
// timing counts in serial clock cycles
`define SBD_DLY_CYC      6'h10
`define SBD_DACK_CYC     6'h20
`define SBD_SYNC_REQ_CYC 8'h80
`define SBD_SYNC_DLY_CYC 8'h10
`define SBD_SYNC_LO_CYC  8'h80
`define SBD_ACK_LO_CYC   8'h10
`define SBD_SAMPLE_CYC   8'h0A
`define SBD_DRIVE_CYC    8'h0D
// control status bit positions
`define SBD_CSR_OVR 0
`define SBD_CSR_ACK 1
`define SBD_CSR_ABG 2
`define SBD_CSR_ILL 3
// command families by upper nibble
`define SBD_F_WR   4'h1
`define SBD_F_RD   4'h3
`define SBD_F_REGW 4'h4
`define SBD_F_SAME 4'h5
`define SBD_F_REGR 4'h6
// single codes
`define SBD_C_NOP    8'h00
`define SBD_C_ACKON  8'h02
`define SBD_C_ACKOFF 8'h03
`define SBD_C_TRACE  8'h07
`define SBD_C_GO     8'h08
`define SBD_C_STEP   8'h09
`define SBD_C_UNTIL  8'h0C
`define SBD_C_CSRW   8'h0D
`define SBD_C_CSRR   8'h2D
`define SBD_C_ERASE  8'h95
`endif

// file: sbd_pkg.sv
`default_nettype none
package sbd_pkg;
  typedef enum logic [3:0] {
    sbd_st_idle  = 4'h0, sbd_st_rx    = 4'h1, sbd_st_disp = 4'h3,
    sbd_st_exec  = 4'h2, sbd_st_wait  = 4'h6, sbd_st_pulse = 4'h7,
    sbd_st_tx    = 4'h5, sbd_st_synch = 4'h4, sbd_st_syncd = 4'hC
  } sbd_st_type;
  typedef enum logic [1:0] {
    sbd_k_none, sbd_k_mem, sbd_k_reg, sbd_k_trace
  } sbd_kind_type;
  typedef enum logic [1:0] {sbd_d_none, sbd_d_plain, sbd_d_ack} sbd_dly_type;
  typedef enum logic [1:0] {sbd_a_given, sbd_a_seq, sbd_a_same} sbd_amode_type;
  typedef enum logic [3:0] {
    sbd_op_nop, sbd_op_go, sbd_op_until, sbd_op_step, sbd_op_ackon,
    sbd_op_ackoff, sbd_op_erase, sbd_op_csrw, sbd_op_csrr
  } sbd_op_type;
  // decoded command shape
  typedef struct packed {
    logic          legal;
    logic          abg;
    logic          addr_in;
    logic [5:0]    wbits;
    logic [5:0]    rbits;
    logic          ws;
    sbd_dly_type   dly;
    sbd_kind_type  kind;
    sbd_amode_type amode;
    sbd_op_type    op;
  } sbd_dec_type;
  // system access request
  typedef struct packed {
    sbd_kind_type kind;
    logic         we;
    logic [1:0]   size;
    logic [23:0]  addr;
    logic [31:0]  wdata;
  } sbd_acc_type;
  typedef struct packed {
    sbd_st_type  st;
    logic        pin_q;
    logic [7:0]  low;
    logic [7:0]  cnt;
    logic        act;
    logic [5:0]  bits;
    logic [1:0]  ph;
    logic [31:0] rsh;
    logic [39:0] tsh;
    logic [7:0]  cmd;
    logic [23:0] addr;
    logic [31:0] wd;
    logic [23:0] seq;
    logic [23:0] same;
    logic        half;
    logic [5:0]  dcnt;
    logic        pend;
    logic        ran;
    logic        sync;
    logic        ack_en;
    logic        ovr;
    logic        ill;
    logic [7:0]  ctl;
    logic        out;
    logic        oe;
    logic        req;
    logic        go;
    logic        step;
    logic        erase;
    sbd_acc_type acc;
    logic [31:0] rd;
  } sbd_state_type;
endpackage : sbd_pkg
`default_nettype wire

// file: sbd_target.sv
`timescale 1ns/1ps
`default_nettype none
`include "sbd_regs.svh"
module sbd_target (
  input  wire logic           clk,
  input  wire logic           sys_rst,
  input  wire logic           ce,
  input  wire logic           pin_in,
  output var  logic           pin_out,
  output var  logic           pin_oe,
  input  wire logic           cpu_halted,
  output var  logic           acc_req,
  output var  sbd_pkg::sbd_acc_type acc,
  input  wire logic           acc_done,
  input  wire logic [31:0]    acc_rdata,
  output var  logic           cpu_go,
  output var  logic           cpu_step,
  output var  logic           erase_req,
  output var  logic [7:0]     debug_ctl
);

  // ====================
  // command decode
  // ====================
  function automatic sbd_pkg::sbd_dec_type decode(input logic [7:0] c);
    sbd_pkg::sbd_dec_type d;
    logic [5:0]           szb;
    d = '0;
    // reserved size code 11 falls through to long
    szb = (c[3:2] == 2'h0) ? 6'h08 : (c[3:2] == 2'h1) ? 6'h10 : 6'h20; // R24
    d.legal = 1'b1;
    d.ws = c[0];
    d.dly = c[0] ? sbd_pkg::sbd_d_plain : sbd_pkg::sbd_d_ack;
    if (c[7:4] == `SBD_F_RD) begin
      d.kind = sbd_pkg::sbd_k_mem; // R1 R8
      d.rbits = szb;
      d.addr_in = ~c[1];
      d.amode = c[1] ? sbd_pkg::sbd_a_seq : sbd_pkg::sbd_a_given;
    end else if (c[7:4] == `SBD_F_WR) begin
      d.kind = sbd_pkg::sbd_k_mem; // R2 R3 R9
      d.wbits = szb;
      d.addr_in = ~c[1];
      d.amode = c[1] ? sbd_pkg::sbd_a_seq : sbd_pkg::sbd_a_given;
    end else if (c[7:4] == `SBD_F_SAME && !c[1]) begin
      d.kind = sbd_pkg::sbd_k_mem; // R11
      d.rbits = szb;
      d.amode = sbd_pkg::sbd_a_same;
    end else begin
      d.ws = 1'b0;
      d.dly = sbd_pkg::sbd_d_ack;
      if (c[7:4] == `SBD_F_REGR) begin
        d.kind = sbd_pkg::sbd_k_reg; // R7
        d.rbits = 6'h20;
        d.abg = 1'b1;
      end else if (c[7:4] == `SBD_F_REGW) begin
        d.kind = sbd_pkg::sbd_k_reg; // R14
        d.wbits = 6'h20;
        d.abg = 1'b1;
      end else begin
        case (c)
          `SBD_C_NOP: d.op = sbd_pkg::sbd_op_nop;
          `SBD_C_ACKON: d.op = sbd_pkg::sbd_op_ackon;
          `SBD_C_ACKOFF: begin
            d.op = sbd_pkg::sbd_op_ackoff;
            d.dly = sbd_pkg::sbd_d_plain;
          end
          `SBD_C_TRACE: begin
            d.kind = sbd_pkg::sbd_k_trace; // R10
            d.rbits = 6'h20;
          end
          `SBD_C_GO: begin
            d.op = sbd_pkg::sbd_op_go; // R4
            d.abg = 1'b1;
          end
          `SBD_C_UNTIL: begin
            d.op = sbd_pkg::sbd_op_until; // R5
            d.abg = 1'b1;
          end
          `SBD_C_STEP: begin
            d.op = sbd_pkg::sbd_op_step; // R16
            d.abg = 1'b1;
          end
          `SBD_C_CSRR: begin
            d.op = sbd_pkg::sbd_op_csrr; // R12
            d.rbits = 6'h10;
            d.dly = sbd_pkg::sbd_d_none;
          end
          `SBD_C_CSRW: begin
            d.op = sbd_pkg::sbd_op_csrw; // R13
            d.wbits = 6'h10;
            d.dly = sbd_pkg::sbd_d_none;
          end
          `SBD_C_ERASE: begin
            d.op = sbd_pkg::sbd_op_erase; // R15
            d.dly = sbd_pkg::sbd_d_plain;
          end
          default: d.legal = 1'b0;
        endcase
      end
    end
    return d;
  endfunction : decode

  // ====================
  // state and derived values
  // ====================
  sbd_pkg::sbd_state_type s;
  sbd_pkg::sbd_state_type next_s;
  sbd_pkg::sbd_dec_type   d;
  logic                   fall;
  logic                   sync_hit;
  logic [31:0]            rnext;
  logic [15:0]            csr;
  logic [23:0]            inc;
  logic                   ackon;
  logic [5:0]             lim;
  logic                   wait_ok;
  logic [31:0]            rdsrc;
  logic [31:0]            rj;
  logic [39:0]            tload;
  logic [5:0]             tlen;
  logic                   post_tx;

  assign d = decode(s.cmd);
  // synchronous pin: the last sample is a safe edge reference
  assign fall = s.pin_q & ~pin_in;
  // only a low far longer than any bit is a sync
  assign sync_hit = ~pin_in & ~s.oe & (s.low == `SBD_SYNC_REQ_CYC - 8'h01); // R19
  assign rnext = {s.rsh[30:0], pin_in};
  assign inc = (s.acc.size == 2'h0) ? 24'h000001 :
               (s.acc.size == 2'h1) ? 24'h000002 : 24'h000004; // R24
  assign ackon = s.ack_en & (d.dly == sbd_pkg::sbd_d_ack);
  // with the handshake off the long wait collapses to the plain delay
  assign lim = (d.dly == sbd_pkg::sbd_d_none) ? 6'h00 :
               ackon ? `SBD_DACK_CYC : `SBD_DLY_CYC; // R26
  // resume-until only waits for reentry when the ack is on
  assign wait_ok = (s.dcnt >= lim) &
                   (~ackon | (d.op != sbd_pkg::sbd_op_until) |
                    (s.ran & cpu_halted)); // R5 R6
  assign rdsrc = (d.op == sbd_pkg::sbd_op_csrr) ? {16'h0000, csr} : s.rd;
  assign rj = rdsrc << (6'h20 - d.rbits);
  assign tload = d.ws ? {csr[7:0], rj} : {rj, 8'h00}; // R27
  assign tlen = d.rbits + (d.ws ? 6'h08 : 6'h00);
  assign post_tx = (tlen != 6'h00);

  // control status word, live status in the low byte
  always_comb begin
    csr = '0;
    csr[15:8] = s.ctl;
    csr[`SBD_CSR_OVR] = s.ovr;
    csr[`SBD_CSR_ACK] = s.ack_en;
    csr[`SBD_CSR_ABG] = cpu_halted;
    csr[`SBD_CSR_ILL] = s.ill;
  end

  // ====================
  // next state
  // ====================
  always_comb begin
    next_s = s;
    next_s.pin_q = pin_in;
    next_s.req = 1'b0;
    next_s.go = 1'b0;
    next_s.step = 1'b0;
    next_s.erase = 1'b0;
    if (pin_in || s.oe) begin
      next_s.low = 8'h00;
    end else if (s.low != `SBD_SYNC_REQ_CYC) begin
      next_s.low = s.low + 8'h01;
    end
    if (s.dcnt != 6'h3F) begin
      next_s.dcnt = s.dcnt + 6'h01;
    end
    if (!cpu_halted) begin
      next_s.ran = 1'b1;
    end
    if (sync_hit) begin
      // drop any command, data or pending ack at once
      next_s.st = sbd_pkg::sbd_st_synch; // R19 R23
      next_s.act = 1'b0;
      next_s.pend = 1'b0;
      next_s.oe = 1'b0;
    end else begin
      unique case (s.st)
        sbd_pkg::sbd_st_idle: begin
          next_s.oe = 1'b0;
          if (fall) begin
            next_s.st = sbd_pkg::sbd_st_rx; // R22
            next_s.act = 1'b1;
            next_s.cnt = 8'h00;
            next_s.bits = 6'h08;
            next_s.ph = 2'h0;
            next_s.half = 1'b0;
          end
        end
        sbd_pkg::sbd_st_rx: begin
          if (!s.act) begin
            if (fall) begin
              next_s.act = 1'b1;
              next_s.cnt = 8'h00;
            end
          end else begin
            next_s.cnt = s.cnt + 8'h01;
            if (s.cnt == `SBD_SAMPLE_CYC) begin
              next_s.rsh = rnext;
              next_s.act = 1'b0;
              next_s.bits = s.bits - 6'h01;
              if (s.bits == 6'h01) begin
                next_s.st = sbd_pkg::sbd_st_disp;
                unique case (s.ph)
                  2'h0: next_s.cmd = rnext[7:0];
                  2'h1: next_s.addr = rnext[23:0];
                  default: next_s.wd = rnext;
                endcase
              end
            end
          end
        end
        sbd_pkg::sbd_st_disp: begin
          if (s.ph == 2'h0 && (!d.legal || (d.abg && !cpu_halted))) begin
            // refused commands leave no ack, only the sticky flag
            next_s.ill = 1'b1;
            next_s.st = sbd_pkg::sbd_st_idle;
          end else if (s.ph == 2'h0 && d.addr_in) begin
            next_s.st = sbd_pkg::sbd_st_rx; // R8 R9
            next_s.bits = 6'h18;
            next_s.ph = 2'h1;
          end else if (s.ph != 2'h2 && d.wbits != 6'h00) begin
            next_s.st = sbd_pkg::sbd_st_rx;
            next_s.bits = d.wbits;
            next_s.ph = 2'h2;
          end else begin
            // launch the access and any control side effect
            next_s.st = sbd_pkg::sbd_st_exec;
            next_s.ph = 2'h2;
            next_s.dcnt = 6'h00;
            next_s.pend = (d.kind != sbd_pkg::sbd_k_none);
            next_s.req = (d.kind != sbd_pkg::sbd_k_none);
            next_s.acc.kind = d.kind;
            next_s.acc.we = (d.wbits != 6'h00);
            next_s.acc.size = (d.kind == sbd_pkg::sbd_k_mem) ? s.cmd[3:2] : 2'h2;
            next_s.acc.wdata = s.wd;
            unique case (d.kind)
              sbd_pkg::sbd_k_reg: next_s.acc.addr = {20'h00000, s.cmd[3:0]}; // R7 R14
              sbd_pkg::sbd_k_trace: next_s.acc.addr = {23'h000000, s.half}; // R10
              default: begin
                unique case (d.amode)
                  sbd_pkg::sbd_a_seq: next_s.acc.addr = s.seq; // R1 R2
                  sbd_pkg::sbd_a_same: next_s.acc.addr = s.same; // R11
                  default: next_s.acc.addr = s.addr;
                endcase
              end
            endcase
            unique case (d.op)
              sbd_pkg::sbd_op_go: next_s.go = 1'b1; // R4 R6
              sbd_pkg::sbd_op_until: begin
                next_s.go = 1'b1; // R5
                next_s.ran = 1'b0;
              end
              sbd_pkg::sbd_op_step: next_s.step = 1'b1; // R16
              sbd_pkg::sbd_op_erase: next_s.erase = 1'b1; // R15
              sbd_pkg::sbd_op_ackon: next_s.ack_en = 1'b1;
              sbd_pkg::sbd_op_ackoff: next_s.ack_en = 1'b0;
              sbd_pkg::sbd_op_csrw: begin
                next_s.ctl = s.wd[15:8]; // R13
                if (s.wd[`SBD_CSR_OVR]) next_s.ovr = 1'b0;
                if (s.wd[`SBD_CSR_ILL]) next_s.ill = 1'b0;
              end
              default: next_s.go = 1'b0;
            endcase
          end
        end
        sbd_pkg::sbd_st_exec: begin
          if (fall) next_s.ovr = 1'b1;
          if (!s.pend || acc_done) begin
            next_s.pend = 1'b0;
            next_s.st = sbd_pkg::sbd_st_wait;
            if (s.pend) next_s.rd = acc_rdata;
            // step the sequential pointer; only an addressed read moves reread
            if (s.acc.kind == sbd_pkg::sbd_k_mem && d.amode != sbd_pkg::sbd_a_same) begin
              next_s.seq = s.acc.addr + inc; // R2
              if (d.amode == sbd_pkg::sbd_a_given && !s.acc.we) begin
                next_s.same = s.acc.addr; // R11
              end
            end
          end
        end
        sbd_pkg::sbd_st_wait: begin
          if (fall) next_s.ovr = 1'b1;
          if (wait_ok) begin
            if (ackon) begin
              next_s.st = sbd_pkg::sbd_st_pulse; // R26
              next_s.cnt = 8'h00;
              next_s.sync = 1'b0;
            end else begin
              next_s.st = post_tx ? sbd_pkg::sbd_st_tx : sbd_pkg::sbd_st_idle; // R1 R3
              next_s.tsh = tload;
              next_s.bits = tlen;
              next_s.act = 1'b0;
            end
          end
        end
        sbd_pkg::sbd_st_pulse: begin
          // low phase, one high speed-up cycle, then release
          next_s.cnt = s.cnt + 8'h01;
          if (s.cnt < (s.sync ? `SBD_SYNC_LO_CYC : `SBD_ACK_LO_CYC)) begin
            next_s.oe = 1'b1;
            next_s.out = 1'b0;
          end else if (s.cnt == (s.sync ? `SBD_SYNC_LO_CYC : `SBD_ACK_LO_CYC)) begin
            next_s.oe = 1'b1;
            next_s.out = 1'b1;
          end else begin
            next_s.oe = 1'b0;
            if (s.sync) begin
              next_s.ovr = 1'b0; // R20
              next_s.st = sbd_pkg::sbd_st_idle; // R22
            end else begin
              next_s.st = post_tx ? sbd_pkg::sbd_st_tx : sbd_pkg::sbd_st_idle;
              next_s.tsh = tload;
              next_s.bits = tlen;
              next_s.act = 1'b0;
            end
          end
        end
        sbd_pkg::sbd_st_tx: begin
          if (!s.act) begin
            if (fall) begin
              next_s.act = 1'b1;
              next_s.cnt = 8'h00;
            end
          end else begin
            next_s.cnt = s.cnt + 8'h01;
            // a zero holds the line low past the host sample point
            if (s.cnt < `SBD_DRIVE_CYC) begin
              next_s.oe = ~s.tsh[39];
              next_s.out = 1'b0;
            end else if (s.cnt == `SBD_DRIVE_CYC) begin
              next_s.oe = ~s.tsh[39];
              next_s.out = 1'b1;
            end else begin
              next_s.oe = 1'b0;
              next_s.act = 1'b0;
              next_s.tsh = {s.tsh[38:0], 1'b0};
              next_s.bits = s.bits - 6'h01;
              if (s.bits == 6'h01) begin
                if (d.kind == sbd_pkg::sbd_k_trace && !s.half) begin
                  next_s.half = 1'b1; // R10
                  next_s.st = sbd_pkg::sbd_st_disp;
                end else begin
                  next_s.st = sbd_pkg::sbd_st_idle;
                end
              end
            end
          end
        end
        sbd_pkg::sbd_st_synch: begin
          if (pin_in) begin
            next_s.st = sbd_pkg::sbd_st_syncd; // R19
            next_s.cnt = 8'h00;
          end
        end
        sbd_pkg::sbd_st_syncd: begin
          next_s.cnt = s.cnt + 8'h01;
          if (s.cnt == `SBD_SYNC_DLY_CYC - 8'h01) begin
            next_s.st = sbd_pkg::sbd_st_pulse; // R19
            next_s.cnt = 8'h00;
            next_s.sync = 1'b1;
          end
        end
        default: next_s.st = sbd_pkg::sbd_st_idle;
      endcase
    end
  end

  // ====================
  // state register
  // ====================
  // clock enable low freezes everything, counters included
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
      s.pin_q <= 1'b1;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // outputs come straight from state flops
  assign pin_out = s.out;
  assign pin_oe = s.oe;
  assign acc_req = s.req;
  assign acc = s.acc;
  assign cpu_go = s.go;
  assign cpu_step = s.step;
  assign erase_req = s.erase;
  assign debug_ctl = s.ctl;

endmodule : sbd_target
`default_nettype wire

// file: sbd_target_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// port checker for the debug pin target
module sbd_target_checker (
  input wire logic                 clk,
  input wire logic                 sys_rst,
  input wire logic                 ce,
  input wire logic                 pin_in,
  input wire logic                 pin_out,
  input wire logic                 pin_oe,
  input wire logic                 cpu_halted,
  input wire logic                 acc_req,
  input wire sbd_pkg::sbd_acc_type acc,
  input wire logic                 acc_done,
  input wire logic [31:0]          acc_rdata,
  input wire logic                 cpu_go,
  input wire logic                 cpu_step,
  input wire logic                 erase_req,
  input wire logic [7:0]           debug_ctl
);
  // target low run, saturating so it cannot wrap
  logic [7:0] low_run;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      low_run <= 8'h00;
    end else if (!(pin_oe && !pin_out)) begin
      low_run <= 8'h00;
    end else if (low_run != 8'hFF) begin
      low_run <= low_run + 8'h01;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // every drive starts low; the shortest low phase is a 13 cycle bit
  sequence s_low8;
    !pin_out [*8];
  endsequence
  // the speed-up pulse lasts one cycle, then the pin is released
  sequence s_pulse_end;
    pin_oe && pin_out ##1 !pin_oe;
  endsequence
  AST_DRIVE_LOW: assert property ($rose(pin_oe) |-> s_low8)
    else $error("drive starts high");
  AST_PULSE_ONE: assert property (pin_oe && pin_out |-> s_pulse_end)
    else $error("long high pulse");
  AST_RELEASE_HIGH: assert property ($fell(pin_oe) |-> $past(pin_out))
    else $error("no high before release");
  AST_LOW_MAX: assert property (low_run <= 8'h80)
    else $error("low drive over 128");
  AST_GO_IN_BG: assert property (cpu_go |-> cpu_halted)
    else $error("resume outside background");
  AST_STEP_IN_BG: assert property (cpu_step |-> cpu_halted)
    else $error("step outside background");
  AST_ACC_KIND: assert property (acc_req |-> acc.kind != sbd_pkg::sbd_k_none)
    else $error("access without kind");
  AST_REG_LONG: assert property (acc_req && acc.kind == sbd_pkg::sbd_k_reg |-> acc.size == 2'h2)
    else $error("register access not 32 bits");
  AST_ERASE_PULSE: assert property (erase_req |=> !erase_req)
    else $error("long erase pulse");
endmodule : sbd_target_checker
bind sbd_target sbd_target_checker chk_u (.clk(clk), .sys_rst(sys_rst), .ce(ce),
  .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .cpu_halted(cpu_halted),
  .acc_req(acc_req), .acc(acc), .acc_done(acc_done), .acc_rdata(acc_rdata),
  .cpu_go(cpu_go), .cpu_step(cpu_step), .erase_req(erase_req), .debug_ctl(debug_ctl));
`default_nettype wire

// file: sbd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// debug host pod: clocks bits on the open-drain pin
module sbd_host_model (
  input  wire logic clk,
  input  wire logic lvl,
  output var  logic host_oe,
  output var  logic host_out
);
  initial begin
    host_oe = 1'b0;
    host_out = 1'b1;
  end
  // host to target, msb first; a one is a short low, a zero outlasts the sample
  task tx(input int n, input logic [31:0] v);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clk);
      host_oe <= 1'b1;
      host_out <= 1'b0;
      repeat (v[i] ? 4 : 14) @(posedge clk);
      host_oe <= 1'b0;
      repeat (v[i] ? 12 : 2) @(posedge clk);
    end
  endtask : tx
  // target to host: one low cycle starts the bit, then listen mid-bit
  task rx(input int n, output logic [31:0] v);
    v = 32'h0;
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clk);
      host_oe <= 1'b1;
      host_out <= 1'b0;
      @(posedge clk);
      host_oe <= 1'b0;
      repeat (6) @(posedge clk);
      v[i] = lvl;
      repeat (12) @(posedge clk);
    end
  endtask : rx
  // long low request; idle high first, speed-up pulse, then release
  task low(input int n);
    repeat (4) @(posedge clk);
    host_oe <= 1'b1;
    host_out <= 1'b0;
    repeat (n) @(posedge clk);
    host_out <= 1'b1;
    @(posedge clk);
    host_oe <= 1'b0;
  endtask : low
endmodule : sbd_host_model
`default_nettype wire

// file: test_single_wire_debug_command_set.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// bench top
module test_single_wire_debug_command_set;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        cpu_halted = 1'b0;
  logic        acc_done = 1'b0;
  logic [31:0] acc_rdata = 32'h0;
  logic [2:0]  done_pipe = 3'h0;
  logic        host_oe;
  logic        host_out;
  logic        wire_lvl;
  logic        pin_out;
  logic        pin_oe;
  logic        acc_req;
  logic        cpu_go;
  logic        cpu_step;
  logic        erase_req;
  logic [7:0]  debug_ctl;
  sbd_pkg::sbd_acc_type acc;
  int n_fail = 0;
  int cmp_count = 0;
  int n_go = 0;
  int n_step = 0;
  int n_erase = 0;
  int cycles = 0;
  // pulled-up wire: low whenever either side drives low
  assign wire_lvl = (host_oe ? host_out : 1'b1) & (pin_oe ? pin_out : 1'b1);
  always #4 clk = ~clk;
  sbd_target dut_u (.clk(clk), .sys_rst(sys_rst), .ce(1'b1), .pin_in(wire_lvl),
    .pin_out(pin_out), .pin_oe(pin_oe), .cpu_halted(cpu_halted), .acc_req(acc_req),
    .acc(acc), .acc_done(acc_done), .acc_rdata(acc_rdata), .cpu_go(cpu_go),
    .cpu_step(cpu_step), .erase_req(erase_req), .debug_ctl(debug_ctl));
  sbd_host_model host_u (.clk(clk), .lvl(wire_lvl), .host_oe(host_oe), .host_out(host_out));
  function automatic logic [31:0] mem_val(input logic [23:0] a);
    return {8'h00, a} ^ 32'h5A5AC3C3;
  endfunction : mem_val
  // system side stand-in: fixed latency, and a resume clears halted until the halt task sets it again
  always @(posedge clk) begin
    done_pipe <= {done_pipe[1:0], acc_req};
    acc_done <= done_pipe[2];
    acc_rdata <= (acc.kind == sbd_pkg::sbd_k_mem) ? mem_val(acc.addr) : {16'hABCD, 15'h0, acc.addr[0]};
    if (cpu_go === 1'b1) begin
      cpu_halted <= 1'b0;
      n_go++;
    end
    if (cpu_step === 1'b1) n_step++;
    if (erase_req === 1'b1) n_erase++;
    cycles++;
    if (cycles == 40000) begin
      n_fail++;
      stop_test();
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task rd_csr(output logic [31:0] v);
    host_u.tx(8, 32'h2D);
    host_u.rx(16, v);
  endtask : rd_csr
  // time from now to the target drive, then the length of its low phase
  task ack(output int g, output int l);
    g = 0;
    l = 0;
    while (pin_oe !== 1'b1 && g < 100) begin
      @(posedge clk);
      g++;
    end
    while (pin_oe === 1'b1 && pin_out === 1'b0 && l < 200) begin
      @(posedge clk);
      l++;
    end
    repeat (4) @(posedge clk);
  endtask : ack
  task halt;
    @(posedge clk);
    cpu_halted <= 1'b1;
  endtask : halt
  // ====================
  // scenarios
  task t_csr;
    logic [31:0] v;
    host_u.tx(8, 32'h0D);
    host_u.tx(16, 32'hA500);
    repeat (4) @(posedge clk);
    chk(debug_ctl, 8'hA5);
    rd_csr(v);
    chk(v, 32'hA500);
  endtask : t_csr
  task t_bg;
    logic [31:0] v;
    host_u.tx(8, 32'h08);
    repeat (30) @(posedge clk);
    chk(n_go, 0);
    rd_csr(v);
    chk(v, 32'hA508);
    host_u.tx(8, 32'h0D);
    host_u.tx(16, 32'hA508);
    halt();
    host_u.tx(8, 32'h08);
    repeat (30) @(posedge clk);
    chk(n_go, 1);
    halt();
    host_u.tx(8, 32'h0C);
    repeat (30) @(posedge clk);
    chk({pin_oe, 31'(n_go)}, 32'h2);
  endtask : t_bg
  task t_mem;
    logic [31:0] r;
    host_u.tx(8, 32'h3D);
    host_u.tx(24, 32'h000200);
    repeat (20) @(posedge clk);
    host_u.rx(8, r);
    host_u.rx(32, r);
    chk(r, mem_val(24'h000200));
    host_u.tx(8, 32'h31);
    host_u.tx(24, 32'h012340);
    repeat (20) @(posedge clk);
    host_u.rx(8, r);
    chk(r, 32'h0);
    host_u.rx(8, r);
    chk(r, mem_val(24'h012340) & 32'hFF);
    chk({acc.we, acc.size, acc.addr}, {1'b0, 2'h0, 24'h012340});
    host_u.tx(8, 32'h37);
    repeat (20) @(posedge clk);
    host_u.rx(8, r);
    host_u.rx(16, r);
    chk(r, mem_val(24'h012341) & 32'hFFFF);
    chk({acc.size, acc.addr}, {2'h1, 24'h012341});
    host_u.tx(8, 32'h51);
    repeat (20) @(posedge clk);
    host_u.rx(8, r);
    host_u.rx(8, r);
    chk(acc.addr, 24'h012340);
  endtask : t_mem
  task t_wr;
    logic [31:0] r;
    host_u.tx(8, 32'h19);
    host_u.tx(24, 32'h000100);
    host_u.tx(32, 32'hDEADBEEF);
    repeat (20) @(posedge clk);
    host_u.rx(8, r);
    chk(r, 32'h0);
    chk({acc.we, acc.size, acc.addr}, {1'b1, 2'h2, 24'h000100});
    chk(acc.wdata, 32'hDEADBEEF);
    host_u.tx(8, 32'h12);
    host_u.tx(8, 32'h77);
    repeat (20) @(posedge clk);
    chk({acc.addr, acc.wdata[7:0]}, {24'h000104, 8'h77});
    host_u.tx(8, 32'h17);
    host_u.tx(16, 32'hBEEF);
    repeat (20) @(posedge clk);
    host_u.rx(8, r);
    chk({acc.addr, acc.wdata[7:0]}, {24'h000105, 8'hEF});
  endtask : t_wr
  task t_sync;
    int g;
    int l;
    logic [31:0] v;
    host_u.low(140);
    ack(g, l);
    chk(l, 128);
    chk(g >= 14 && g <= 18, 1);
    rd_csr(v);
    chk(v[0], 0);
  endtask : t_sync
  task t_ack;
    int g;
    int l;
    logic [31:0] r;
    host_u.tx(8, 32'h95);
    host_u.tx(1, 32'h1);
    repeat (30) @(posedge clk);
    chk(n_erase, 1);
    rd_csr(r);
    chk(r[0], 1);
    t_sync();
    host_u.tx(8, 32'h02);
    ack(g, l);
    chk(l, 16);
    halt();
    host_u.tx(8, 32'h09);
    ack(g, l);
    chk({g >= 24, 31'(l)}, 32'h80000010);
    chk(n_step, 1);
    host_u.tx(8, 32'h43);
    host_u.tx(32, 32'h13572468);
    ack(g, l);
    chk({acc.kind, acc.addr[3:0], acc.wdata[25:0]}, {2'h2, 4'h3, 26'h3572468});
    host_u.tx(8, 32'h65);
    ack(g, l);
    host_u.rx(32, r);
    chk(r, 32'hABCD0001);
    host_u.tx(8, 32'h07);
    ack(g, l);
    host_u.rx(32, r);
    chk(r, 32'hABCD0000);
    ack(g, l);
    host_u.rx(32, r);
    chk(r, 32'hABCD0001);
    host_u.tx(8, 32'h0C);
    ack(g, l);
    chk(g, 100);
    t_sync();
  endtask : t_ack
  task stop_test;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_csr();
    t_bg();
    t_mem();
    t_wr();
    t_ack();
    stop_test();
  end
endmodule : test_single_wire_debug_command_set
`default_nettype wire
